// ===== rtl/fcbm_core.sv
/*
 * Flash mode control register, code-space map and flash service
 * sequencer that carries out the boot service calls.
 * Assumes the CPU reports calls, returns and the fetch region, gives a
 * call as a one-cycle pulse, and that the flash array reads combinationally.
 */
// Contract
// - map 00 all user, 01 split at 63 K, 11 all boot ROM.
// - map 10 splits too; upper bit cleared while executing in user region.
// - bit 5 reads one exactly while programming high voltage is present.
// - function codes 0, 5, C, 3, A: idle, byte, page, block, full.
// - under security only internal flash code may load non-full-erase codes.
// - operation duration comes from an internal timer, not from software.
// - service leaves everything but control, accumulator and pointer alone.
// - byte read at FFBA, 45 in; returns byte, same address, 15 out.
// - byte write at FFAD, 45 in; returns verified byte, 15 out.
// - page erase at FFAA, 4C in; acc 08, low 5 pointer bits zero, 1C.
// - block erase at FFA5, 43 in; acc 02, low pointer byte 08, 13.
// - full erase at FFA0, 4A in; acc 0A, pointer 0018, 1A out.
// - return below 63 K out of boot ROM clears both map bits.
// - serial boot strap at reset sets both map bits to one.
// - no flash access or fetch while an erase or write runs.
`timescale 1ns/10ps
module fcbm_core #(
    parameter int TICK_CYCLES = fcbm_pkg::TICK_CYCLES,
    parameter int WRITE_TICKS = fcbm_pkg::WRITE_TIME_US,
    parameter int ERASE_TICKS = fcbm_pkg::ERASE_TIME_US
) (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // special function register port
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // cpu context
    input  wire logic [15:0] pc_i,
    input  wire logic        exec_internal_i,
    input  wire logic        ret_i,
    input  wire logic [15:0] ret_target_i,
    input  wire logic        security_i,
    input  wire logic        boot_strap_i,
    input  wire logic [15:0] code_addr_i,
    input  wire logic        code_fetch_flash_i,
    output logic             boot_rom_sel_o,
    output logic             fetch_stall_o,
    // service call
    input  wire logic        svc_call_i,
    input  wire logic [15:0] svc_entry_i,
    input  wire logic [7:0]  svc_acc_i,
    input  wire logic [15:0] svc_address_pointer_i,
    output logic             svc_done_o,
    output logic      [7:0]  svc_acc_o,
    output logic      [15:0] svc_address_pointer_o,
    // flash array
    output logic      [3:0]  flash_cmd_o,
    output logic      [15:0] flash_addr_o,
    output logic      [7:0]  flash_wdata_o,
    input  wire logic [7:0]  flash_rdata_i,
    output logic             high_voltage_flag_o
);
    typedef enum logic [1:0] {
        FCBM_ST_IDLE = 2'b00,
        FCBM_ST_RUN  = 2'b01,
        FCBM_ST_READ = 2'b11
    } fcbm_state_type;

    fcbm_state_type state;
    fcbm_state_type next_state;
    logic [1:0]  map_bits;
    logic [1:0]  next_map_bits;
    logic        rsv;
    logic        next_rsv;
    logic [3:0]  func;
    logic [3:0]  next_func;
    logic        first;
    logic        next_first;
    logic [7:0]  next_rdata;
    logic        next_done;
    logic [7:0]  next_acc;
    logic [15:0] next_address_pointer;
    logic [3:0]  next_cmd;
    logic [15:0] next_faddr;
    logic [7:0]  next_wdata;
    logic        start;
    logic        erase;
    logic        hv;
    logic        op_done;
    logic [7:0]  fmc_view;
    logic        match;

    function automatic logic in_boot(input logic [1:0] m,
                                     input logic [15:0] a);
        unique case (m)
            fcbm_pkg::FCBM_MAP_USER: in_boot = 1'b0;
            fcbm_pkg::FCBM_MAP_BOOT: in_boot = 1'b1;
            default: in_boot = (a >= fcbm_pkg::BOOT_BORDER);
        endcase
    endfunction

    // ------------------------------------------------------------
    // map decode and fetch guard
    // ------------------------------------------------------------
    assign fmc_view = {map_bits, hv, rsv, func};
    assign boot_rom_sel_o = in_boot(map_bits, code_addr_i);
    assign fetch_stall_o = hv && code_fetch_flash_i;
    assign high_voltage_flag_o = hv;

    fcbm_op_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .WRITE_TICKS(WRITE_TICKS),
        .ERASE_TICKS(ERASE_TICKS)
    ) fcbm_op_timer_inst (
        .core_clk_i(core_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start),
        .erase_i   (erase),
        .busy_o    (hv),
        .done_o    (op_done)
    );

    // ------------------------------------------------------------
    // register and sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_map_bits = map_bits;
        next_rsv = rsv;
        next_func = func;
        next_first = 1'b0;
        next_done = 1'b0;
        next_acc = svc_acc_o;
        next_address_pointer = svc_address_pointer_o;
        next_cmd = flash_cmd_o;
        next_faddr = flash_addr_o;
        next_wdata = flash_wdata_o;
        next_rdata = (sfr_addr_i == fcbm_pkg::FMC_ADDR) ? fmc_view : 8'h00;
        start = 1'b0;
        erase = 1'b0;
        match = 1'b0;
        if (first && boot_strap_i) begin
            next_map_bits = fcbm_pkg::FCBM_MAP_BOOT;
        end
        if (sfr_wr_i && sfr_addr_i == fcbm_pkg::FMC_ADDR) begin
            next_map_bits = sfr_wdata_i[fcbm_pkg::FMC_UPPER_BIT:
                                        fcbm_pkg::FMC_LOWER_BIT];
            next_rsv = sfr_wdata_i[fcbm_pkg::FMC_RSV_BIT];
            // protected code bits: only full erase may pass from outside
            if (!security_i || exec_internal_i ||
                sfr_wdata_i[3:0] == fcbm_pkg::FCBM_FN_FULL) begin
                next_func = sfr_wdata_i[3:0];
            end
        end
        if (map_bits == fcbm_pkg::FCBM_MAP_HW && pc_i < fcbm_pkg::BOOT_BORDER)
        begin
            next_map_bits[1] = 1'b0;
        end
        if (ret_i && in_boot(map_bits, pc_i) &&
            ret_target_i < fcbm_pkg::BOOT_BORDER) begin
            next_map_bits = fcbm_pkg::FCBM_MAP_USER;
        end
        unique case (state)
            FCBM_ST_IDLE: begin
                if (svc_call_i) begin
                    next_done = 1'b1;
                    next_acc = svc_acc_i;
                    next_address_pointer = svc_address_pointer_i;
                    next_faddr = svc_address_pointer_i;
                    next_wdata = svc_acc_i;
                    // the array only sees a code once a routine really runs
                    if (svc_entry_i == fcbm_pkg::ENT_READ &&
                        fmc_view == fcbm_pkg::IN_BYTE) begin
                        next_done = 1'b0;
                        next_cmd = func;
                        next_state = FCBM_ST_READ;
                    end else begin
                        match = (svc_entry_i == fcbm_pkg::ENT_WRITE &&
                                 fmc_view == fcbm_pkg::IN_BYTE) ||
                                (svc_entry_i == fcbm_pkg::ENT_PAGE &&
                                 fmc_view == fcbm_pkg::IN_PAGE) ||
                                (svc_entry_i == fcbm_pkg::ENT_BLOCK &&
                                 fmc_view == fcbm_pkg::IN_BLOCK) ||
                                (svc_entry_i == fcbm_pkg::ENT_FULL &&
                                 fmc_view == fcbm_pkg::IN_FULL);
                        if (match) begin
                            start = 1'b1;
                            next_cmd = func;
                            erase = (func != fcbm_pkg::FCBM_FN_BYTE);
                            next_done = 1'b0;
                            next_state = FCBM_ST_RUN;
                        end
                    end
                end
            end
            FCBM_ST_RUN: begin
                if (op_done) begin
                    next_done = 1'b1;
                    next_cmd = fcbm_pkg::FCBM_FN_IDLE;
                    unique case (func)
                        fcbm_pkg::FCBM_FN_PAGE: begin
                            next_acc = fcbm_pkg::ACC_PAGE;
                            next_address_pointer = {flash_addr_o[15:5], 5'h00};
                        end
                        fcbm_pkg::FCBM_FN_BLOCK: begin
                            next_acc = fcbm_pkg::ACC_BLOCK;
                            next_address_pointer = {flash_addr_o[15:8],
                                         fcbm_pkg::PTR_BLOCK};
                        end
                        fcbm_pkg::FCBM_FN_FULL: begin
                            next_acc = fcbm_pkg::ACC_FULL;
                            next_address_pointer = fcbm_pkg::PTR_FULL;
                        end
                        default: begin
                            // byte write: read back for verification
                            next_done = 1'b0;
                            next_cmd = func;
                            next_state = FCBM_ST_READ;
                        end
                    endcase
                    // exit values only when the routine returns, so a
                    // pending return or hardware clear is not undone
                    if (next_done) begin
                        next_rsv = 1'b1;
                        next_map_bits = fcbm_pkg::FCBM_MAP_USER;
                        next_state = FCBM_ST_IDLE;
                    end
                end
            end
            FCBM_ST_READ: begin
                next_acc = flash_rdata_i;
                next_rsv = 1'b1;
                next_map_bits = fcbm_pkg::FCBM_MAP_USER;
                next_cmd = fcbm_pkg::FCBM_FN_IDLE;
                next_done = 1'b1;
                next_state = FCBM_ST_IDLE;
            end
            default: next_state = FCBM_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= FCBM_ST_IDLE;
            map_bits <= fcbm_pkg::MAP_RESET;
            rsv <= 1'b0;
            func <= fcbm_pkg::FUNC_RESET;
            first <= 1'b1;
            sfr_rdata_o <= 8'h00;
            svc_done_o <= 1'b0;
            svc_acc_o <= 8'h00;
            svc_address_pointer_o <= 16'h0000;
            flash_cmd_o <= 4'h0;
            flash_addr_o <= 16'h0000;
            flash_wdata_o <= 8'h00;
        end else begin
            state <= next_state;
            map_bits <= next_map_bits;
            rsv <= next_rsv;
            func <= next_func;
            first <= next_first;
            sfr_rdata_o <= next_rdata;
            svc_done_o <= next_done;
            svc_acc_o <= next_acc;
            svc_address_pointer_o <= next_address_pointer;
            flash_cmd_o <= next_cmd;
            flash_addr_o <= next_faddr;
            flash_wdata_o <= next_wdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    hv_tracks_run_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) hv |-> state == FCBM_ST_RUN)
        else $error("high voltage outside a running operation");
    undef_no_hv_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (state == FCBM_ST_IDLE && !match) |=> !hv)
        else $error("high voltage without a defined operation");
    fetch_block_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        fetch_stall_o == (hv && code_fetch_flash_i))
        else $error("flash fetch guard wrong during operation");
    secure_func_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (sfr_wr_i && sfr_addr_i == fcbm_pkg::FMC_ADDR && security_i &&
         !exec_internal_i && sfr_wdata_i[3:0] != fcbm_pkg::FCBM_FN_FULL &&
         state == FCBM_ST_IDLE) |=> $stable(func))
        else $error("protected function code changed");
    ret_clear_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (ret_i && in_boot(map_bits, pc_i) && state == FCBM_ST_IDLE &&
         ret_target_i < fcbm_pkg::BOOT_BORDER && !sfr_wr_i)
        |=> map_bits == 2'h0)
        else $error("map not cleared on return");
    hw_clear_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (map_bits == 2'h2 && pc_i < fcbm_pkg::BOOT_BORDER && !sfr_wr_i)
        |=> !map_bits[1])
        else $error("upper map bit kept in user region");
    full_result_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (svc_done_o && $past(state) == FCBM_ST_RUN &&
         $past(func) == fcbm_pkg::FCBM_FN_FULL)
        |-> svc_address_pointer_o == 16'h0018 && svc_acc_o == 8'h0A)
        else $error("full erase result wrong");
    write_timed_a: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        $rose(hv) |-> hv [*8])
        else $error("operation ended too early");
endmodule

// ===== rtl/fcbm_op_timer.sv
/*
 * Operation timer: a free-running divider stands in for the internal
 * oscillator and paces a tick counter that times one write or erase.
 * Assumes start_i is a one-cycle pulse given only while busy_o is low.
 */
`timescale 1ns/10ps
module fcbm_op_timer #(
    parameter int TICK_CYCLES = fcbm_pkg::TICK_CYCLES,
    parameter int WRITE_TICKS = fcbm_pkg::WRITE_TIME_US,
    parameter int ERASE_TICKS = fcbm_pkg::ERASE_TIME_US
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // control
    input  wire logic start_i,
    input  wire logic erase_i,
    output logic      busy_o,
    output logic      done_o
);
    logic [15:0] div;
    logic [15:0] next_div;
    logic [15:0] ticks;
    logic [15:0] next_ticks;
    logic        busy;
    logic        next_busy;
    logic        next_done;
    logic        tick;

    // divider free-runs: software has no handle on the duration
    always_comb begin
        tick = (div == 16'(TICK_CYCLES - 1));
        next_div = tick ? 16'h0000 : div + 16'h0001;
        next_busy = busy;
        next_ticks = ticks;
        next_done = 1'b0;
        if (start_i && !busy) begin
            next_busy = 1'b1;
            next_ticks = erase_i ? 16'(ERASE_TICKS) : 16'(WRITE_TICKS);
        end else if (busy && tick) begin
            if (ticks == 16'h0001) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
            next_ticks = ticks - 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div <= 16'h0000;
            ticks <= 16'h0000;
            busy <= 1'b0;
            done_o <= 1'b0;
        end else begin
            div <= next_div;
            ticks <= next_ticks;
            busy <= next_busy;
            done_o <= next_done;
        end
    end

    assign busy_o = busy;
endmodule

// ===== rtl/fcbm_pkg.sv
/*
 * Constants for the flash mode control register, the code-space map
 * and the flash service sequencer.
 * Assumes a 100 MHz core clock and an 8-bit special function register bus.
 */
package fcbm_pkg;
    // ------------------------------------------------------------
    // register and fields
    // ------------------------------------------------------------
    localparam logic [7:0] FMC_ADDR      = 8'hFB;
    localparam int         FMC_UPPER_BIT = 7;
    localparam int         FMC_LOWER_BIT = 6;
    localparam int         FMC_HV_BIT    = 5;
    localparam int         FMC_RSV_BIT   = 4;
    localparam logic [1:0] MAP_RESET     = 2'h0;
    localparam logic [3:0] FUNC_RESET    = 4'h0;

    typedef enum logic [3:0] {
        FCBM_FN_IDLE  = 4'h0,
        FCBM_FN_BYTE  = 4'h5,
        FCBM_FN_PAGE  = 4'hC,
        FCBM_FN_BLOCK = 4'h3,
        FCBM_FN_FULL  = 4'hA
    } fcbm_func_type;

    typedef enum logic [1:0] {
        FCBM_MAP_USER = 2'h0,
        FCBM_MAP_SPLIT = 2'h1,
        FCBM_MAP_HW   = 2'h2,
        FCBM_MAP_BOOT = 2'h3
    } fcbm_map_type;

    // ------------------------------------------------------------
    // code space
    // ------------------------------------------------------------
    localparam logic [15:0] BOOT_BORDER = 16'hFC00;

    // ------------------------------------------------------------
    // service routine entries, control values in and out
    // ------------------------------------------------------------
    localparam logic [15:0] ENT_READ  = 16'hFFBA;
    localparam logic [15:0] ENT_WRITE = 16'hFFAD;
    localparam logic [15:0] ENT_PAGE  = 16'hFFAA;
    localparam logic [15:0] ENT_BLOCK = 16'hFFA5;
    localparam logic [15:0] ENT_FULL  = 16'hFFA0;
    localparam logic [7:0]  IN_BYTE   = 8'h45;
    localparam logic [7:0]  IN_PAGE   = 8'h4C;
    localparam logic [7:0]  IN_BLOCK  = 8'h43;
    localparam logic [7:0]  IN_FULL   = 8'h4A;
    localparam logic [7:0]  ACC_PAGE  = 8'h08;
    localparam logic [7:0]  ACC_BLOCK = 8'h02;
    localparam logic [7:0]  ACC_FULL  = 8'h0A;
    localparam logic [7:0]  PTR_BLOCK = 8'h08;
    localparam logic [15:0] PTR_FULL  = 16'h0018;

    // ------------------------------------------------------------
    // operation timing
    // ------------------------------------------------------------
    localparam int TICK_NS       = 1000;
    localparam int CLK_NS        = 10;
    localparam int TICK_CYCLES   = TICK_NS / CLK_NS;
    localparam int WRITE_TIME_US = 2500;
    localparam int ERASE_TIME_US = 5000;
endpackage

// ===== verif/flash_control_boot_map_bench.sv
/*
 * Self-checking bench for the flash mode control register, code-space
 * map and service sequencer.
 * Assumes a flash array that reads combinationally and never changes.
 */
`timescale 1ns/10ps
module flash_control_boot_map_bench;
    // short counts keep the timed operations to about a dozen cycles;
    // the shortest busy time (ticks - 1) * TC + 1 must stay at 8 or more
    localparam int TC = 2;
    localparam int WT = 5;
    localparam int ET = 5;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        core_clk_i         = 1'b0;
    logic        sys_rst_i          = 1'b1;
    logic [7:0]  sfr_addr_i         = 8'h00;
    logic        sfr_wr_i           = 1'b0;
    logic [7:0]  sfr_wdata_i        = 8'h00;
    logic [15:0] pc_i               = 16'h0100;
    logic        exec_internal_i    = 1'b1;
    logic        ret_i              = 1'b0;
    logic [15:0] ret_target_i       = 16'h0000;
    logic        security_i         = 1'b0;
    logic        boot_strap_i       = 1'b0;
    logic [15:0] code_addr_i        = 16'h0000;
    logic        code_fetch_flash_i = 1'b1;
    logic        svc_call_i         = 1'b0;
    logic [15:0] svc_entry_i        = 16'h0000;
    logic [7:0]  svc_acc_i          = 8'h00;
    logic [15:0] svc_address_pointer_i         = 16'h0000;
    logic [7:0]  flash_rdata_i;
    logic [7:0]  sfr_rdata_o;
    logic        boot_rom_sel_o;
    logic        fetch_stall_o;
    logic        svc_done_o;
    logic [7:0]  svc_acc_o;
    logic [15:0] svc_address_pointer_o;
    logic [3:0]  flash_cmd_o;
    logic [15:0] flash_addr_o;
    logic [7:0]  flash_wdata_o;
    logic        high_voltage_flag_o;
    int          bad_count          = 0;
    int          n_checks           = 0;
    int          cyc                = 0;

    // array content is a fixed pattern of the address
    assign flash_rdata_i = flash_addr_o[7:0] ^ 8'h5A;

    fcbm_core #(.TICK_CYCLES(TC), .WRITE_TICKS(WT), .ERASE_TICKS(ET))
    fcbm_core_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .pc_i(pc_i), .exec_internal_i(exec_internal_i), .ret_i(ret_i),
        .ret_target_i(ret_target_i), .security_i(security_i),
        .boot_strap_i(boot_strap_i), .code_addr_i(code_addr_i),
        .code_fetch_flash_i(code_fetch_flash_i),
        .boot_rom_sel_o(boot_rom_sel_o), .fetch_stall_o(fetch_stall_o),
        .svc_call_i(svc_call_i), .svc_entry_i(svc_entry_i),
        .svc_acc_i(svc_acc_i), .svc_address_pointer_i(svc_address_pointer_i),
        .svc_done_o(svc_done_o), .svc_acc_o(svc_acc_o),
        .svc_address_pointer_o(svc_address_pointer_o), .flash_cmd_o(flash_cmd_o),
        .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
        .flash_rdata_i(flash_rdata_i),
        .high_voltage_flag_o(high_voltage_flag_o));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(negedge core_clk_i);
        sfr_addr_i  = fcbm_pkg::FMC_ADDR;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        @(negedge core_clk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] ad,
                      input logic [7:0] e);
        @(negedge core_clk_i);
        sfr_addr_i = ad;
        @(negedge core_clk_i);
        chk(nm, {8'h00, e}, {8'h00, sfr_rdata_o});
    endtask

    task automatic sel(input logic [15:0] a, input logic e);
        @(negedge core_clk_i);
        code_addr_i = a;
        #1;
        chk("boot_rom_sel", {15'h0, e}, {15'h0, boot_rom_sel_o});
    endtask

    task automatic svc(input logic [15:0] ent, input logic [7:0] ctl,
        input logic [7:0] ea, input logic [15:0] ep, input logic [3:0] cmd,
        input int lo, input int hi, input logic [7:0] eo);
        int n;
        int hv;
        n  = 0;
        hv = 0;
        wr(ctl);
        @(negedge core_clk_i);
        svc_call_i  = 1'b1;
        svc_entry_i = ent;
        svc_acc_i   = 8'h77;
        svc_address_pointer_i  = 16'h1263;
        @(negedge core_clk_i);
        svc_call_i = 1'b0;
        while (svc_done_o !== 1'b1 && n < 400) begin
            if (high_voltage_flag_o === 1'b1) begin
                if (hv == 0) begin
                    chk("flash_cmd", {12'h0, cmd}, {12'h0, flash_cmd_o});
                    chk("fetch_stall", 16'h1, {15'h0, fetch_stall_o});
                    if (cmd == 4'h5) begin
                        chk("flash_wdata", 16'h0077,
                            {8'h00, flash_wdata_o});
                    end
                end
                hv++;
            end
            n++;
            @(negedge core_clk_i);
        end
        chk("svc_done", 16'h1, {15'h0, svc_done_o});
        chk("svc_acc", {8'h00, ea}, {8'h00, svc_acc_o});
        chk("svc_address_pointer", ep, svc_address_pointer_o);
        chk("flash_addr", 16'h1263, flash_addr_o);
        chk("flash_cmd_end", 16'h0, {12'h0, flash_cmd_o});
        chk("fetch_free", 16'h0, {15'h0, fetch_stall_o});
        chk("hv_time", 16'h1, {15'h0, hv >= lo && hv <= hi});
        rd("ctl_out", fcbm_pkg::FMC_ADDR, eo);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reg();
        rd("ctl_reset", fcbm_pkg::FMC_ADDR, 8'h00);
        wr(8'h25);
        rd("hv_read_only", fcbm_pkg::FMC_ADDR, 8'h05);
        rd("unmapped", 8'h80, 8'h00);
    endtask

    task automatic t_secure();
        security_i      = 1'b1;
        exec_internal_i = 1'b0;
        wr(8'h03);
        rd("func_locked", fcbm_pkg::FMC_ADDR, 8'h05);
        wr(8'h0A);
        rd("func_full_ok", fcbm_pkg::FMC_ADDR, 8'h0A);
        exec_internal_i = 1'b1;
        wr(8'h0C);
        rd("func_internal", fcbm_pkg::FMC_ADDR, 8'h0C);
        security_i = 1'b0;
        wr(8'h00);
    endtask

    task automatic t_map();
        pc_i = 16'hFF00;
        sel(16'hFC00, 1'b0);
        wr(8'h40);
        sel(16'hFC00, 1'b1);
        sel(16'hFBFF, 1'b0);
        wr(8'hC0); // upper bit only from the boot region
        sel(16'h0000, 1'b1);
        wr(8'h80);
        sel(16'hFC00, 1'b1);
        sel(16'hFBFF, 1'b0);
        pc_i = 16'h0100;
        rd("upper_cleared", fcbm_pkg::FMC_ADDR, 8'h00);
    endtask

    task automatic t_ret();
        pc_i = 16'hFF00;
        wr(8'h40);
        @(negedge core_clk_i);
        ret_i        = 1'b1;
        ret_target_i = 16'h0100;
        @(negedge core_clk_i);
        ret_i = 1'b0;
        pc_i  = 16'h0100;
        rd("ret_clears_map", fcbm_pkg::FMC_ADDR, 8'h00);
    endtask

    task automatic t_strap();
        @(negedge core_clk_i);
        sys_rst_i    = 1'b1;
        boot_strap_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rd("strap_map", fcbm_pkg::FMC_ADDR, 8'hC0);
        sel(16'h0000, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // sequence and hang guard
    // ----------------------------------------------------------------
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            $display("[ERR] cycle_limit expected below 5000 seen %0d", cyc);
            end_of_test();
        end
    end

    initial begin
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_reg();
        t_secure();
        t_map();
        t_ret();
        svc(fcbm_pkg::ENT_READ, fcbm_pkg::IN_BYTE, 8'h39, 16'h1263, 4'h5,
            0, 0, 8'h15);
        svc(fcbm_pkg::ENT_WRITE, fcbm_pkg::IN_BYTE, 8'h39, 16'h1263, 4'h5,
            (WT - 1) * TC + 1, WT * TC + TC + 3, 8'h15);
        svc(fcbm_pkg::ENT_PAGE, fcbm_pkg::IN_PAGE, 8'h08, 16'h1260, 4'hC,
            (ET - 1) * TC + 1, ET * TC + TC + 3, 8'h1C);
        svc(fcbm_pkg::ENT_BLOCK, fcbm_pkg::IN_BLOCK, 8'h02, 16'h1208, 4'h3,
            (ET - 1) * TC + 1, ET * TC + TC + 3, 8'h13);
        svc(fcbm_pkg::ENT_FULL, fcbm_pkg::IN_FULL, 8'h0A, 16'h0018, 4'hA,
            (ET - 1) * TC + 1, ET * TC + TC + 3, 8'h1A);
        svc(fcbm_pkg::ENT_WRITE, 8'h47, 8'h77, 16'h1263, 4'h0,
            0, 0, 8'h47);
        t_strap();
        end_of_test();
    end
endmodule
